// ==== rtl/vcb_pkg.sv ====
// constants and types shared by the csr set/clear bank
package vcb_pkg;
  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [11:0] off_addr_shift   = 12'hfd8;
  localparam logic [11:0] off_bit_clear    = 12'hff4;
  localparam logic [11:0] off_bit_set      = 12'hff8;
  localparam logic [11:0] off_window_base  = 12'hffc;
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int          bit_board_reset  = 31;
  localparam int          bit_sys_fail     = 30;
  localparam int          bit_board_fail   = 29;
  localparam int          window_hi        = 31;
  localparam int          window_lo        = 27;
  localparam int          shift_lo         = 16;
  localparam int          csr_addr_hi      = 23;
  localparam int          csr_addr_lo      = 19;
  localparam logic [4:0]  window_count     = 5'h1f;
  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [4:0]  window_reset     = 5'h00;
  localparam logic [15:0] shift_reset      = 16'h0000;
  localparam logic        board_reset_init = 1'b0;
  localparam logic        board_fail_init  = 1'b0;
  typedef enum logic [1:0] {
    vcb_sel_none,
    vcb_sel_clear,
    vcb_sel_set,
    vcb_sel_base
  } vcb_sel_type;
endpackage

// ==== rtl/vcb_xlate_if.sv ====
// carrier between the bank and the address translator
interface vcb_xlate_if;
  logic [15:0] shift;
  logic [31:0] src_addr;
  logic [31:0] dst_addr;
  modport bank  (output shift, output src_addr, input dst_addr);
  modport xlate (input shift, input src_addr, output dst_addr);
endinterface

// ==== rtl/vcb_xlate.sv ====
// address translation adder for slave window seven
module vcb_xlate (
  input  wire logic clk,
  input  wire logic rst,
  vcb_xlate_if.xlate port
);
  logic [31:0] next_dst;
  logic [31:0] dst;
  // ----------------------------------------
  // translation
  // ----------------------------------------
  always_comb begin
    // negative shifts wrap as two's complement
    next_dst = port.src_addr + {port.shift, 16'h0000};
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dst <= 32'h0000_0000;
    end else begin
      dst <= next_dst;
    end
  end
  assign port.dst_addr = dst;
endmodule

// ==== rtl/vcb_bank.sv ====
// csr bit set / bit clear / window base bank with window seven shift
module vcb_bank (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        sysfail_strap,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic        from_backplane,
  input  wire logic [11:0] reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic [3:0]  reg_be,
  output logic      [31:0] reg_rdata,
  input  wire logic [23:0] csr_addr,
  output logic             csr_hit,
  input  wire logic [31:0] src_addr,
  output logic      [31:0] dst_addr,
  output logic             local_board_reset_out,
  output logic             backplane_fail_drive
);
  logic [4:0]  csr_window_select;
  logic [15:0] addr_shift_field;
  logic [7:0]  shift_byte [2];
  logic        board_reset;
  logic        sys_fail;
  logic        strap_done;
  logic [4:0]  next_csr_window_select;
  logic        next_board_reset;
  logic        next_sys_fail;
  logic        next_strap_done;
  logic        top_lane_wr;
  logic        shift_sel;
  logic [31:0] next_rdata;
  logic [31:0] rdata;
  logic        next_hit;
  logic        hit;
  vcb_pkg::vcb_sel_type sel;

  vcb_xlate_if xl ();

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  function automatic vcb_pkg::vcb_sel_type decode(input logic [11:0] a);
    if (a == vcb_pkg::off_bit_clear) begin
      return vcb_pkg::vcb_sel_clear;
    end else if (a == vcb_pkg::off_bit_set) begin
      return vcb_pkg::vcb_sel_set;
    end else if (a == vcb_pkg::off_window_base) begin
      return vcb_pkg::vcb_sel_base;
    end
    return vcb_pkg::vcb_sel_none;
  endfunction

  // the shift register sits outside the csr trio, so it gets its own test
  function automatic logic is_shift(input logic [11:0] a);
    return a == vcb_pkg::off_addr_shift;
  endfunction

  assign sel         = decode(reg_addr);
  assign shift_sel   = is_shift(reg_addr);
  // clear, set and base all live in the top byte lane
  assign top_lane_wr = reg_wr && reg_be[3];

  // ----------------------------------------
  // board reset and sysfail
  // ----------------------------------------
  always_comb begin
    next_board_reset = board_reset;
    next_sys_fail    = sys_fail;
    next_strap_done  = 1'b1;
    if (!strap_done) begin
      // sysfail default is caught after reset release
      // limitation: a sysfail write on that same edge beats the strap
      next_sys_fail = sysfail_strap;
    end
    if (top_lane_wr) begin
      unique case (sel)
        vcb_pkg::vcb_sel_clear: begin
          // local side may not touch board reset
          if (from_backplane && reg_wdata[vcb_pkg::bit_board_reset]) begin
            next_board_reset = 1'b0;
          end
          if (reg_wdata[vcb_pkg::bit_sys_fail]) begin
            next_sys_fail = 1'b0;
          end
        end
        vcb_pkg::vcb_sel_set: begin
          if (from_backplane && reg_wdata[vcb_pkg::bit_board_reset]) begin
            next_board_reset = 1'b1;
          end
          if (reg_wdata[vcb_pkg::bit_sys_fail]) begin
            next_sys_fail = 1'b1;
          end
        end
        vcb_pkg::vcb_sel_base, vcb_pkg::vcb_sel_none: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      board_reset <= vcb_pkg::board_reset_init;
      sys_fail    <= 1'b0;
      strap_done  <= 1'b0;
    end else begin
      board_reset <= next_board_reset;
      sys_fail    <= next_sys_fail;
      strap_done  <= next_strap_done;
    end
  end

  // ----------------------------------------
  // window base
  // ----------------------------------------
  always_comb begin
    next_csr_window_select = csr_window_select;
    if (top_lane_wr && sel == vcb_pkg::vcb_sel_base) begin
      // only the top byte lane carries the base, so byte writes suffice
      next_csr_window_select =
        reg_wdata[vcb_pkg::window_hi:vcb_pkg::window_lo];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      csr_window_select <= vcb_pkg::window_reset;
    end else begin
      csr_window_select <= next_csr_window_select;
    end
  end

  // ----------------------------------------
  // window seven shift, one byte lane per slice
  // ----------------------------------------
  // lane 0 is bits 23:16 under be[2], lane 1 is bits 31:24 under be[3]
  for (genvar lane = 0; lane < 2; lane++) begin : g_shift_lane
    logic [7:0] next_shift_byte;
    always_comb begin
      next_shift_byte = shift_byte[lane];
      if (reg_wr && shift_sel && reg_be[2+lane]) begin
        next_shift_byte = reg_wdata[vcb_pkg::shift_lo+8*lane +: 8];
      end
    end
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        shift_byte[lane] <= vcb_pkg::shift_reset[8*lane +: 8];
      end else begin
        shift_byte[lane] <= next_shift_byte;
      end
    end
  end

  assign addr_shift_field = {shift_byte[1], shift_byte[0]};

  // ----------------------------------------
  // read data and window match
  // ----------------------------------------
  always_comb begin
    next_rdata = rdata;
    if (reg_rd) begin
      next_rdata = 32'h0000_0000;
      unique case (sel)
        vcb_pkg::vcb_sel_clear, vcb_pkg::vcb_sel_set: begin
          next_rdata[vcb_pkg::bit_board_reset] = board_reset;
          next_rdata[vcb_pkg::bit_sys_fail]    = sys_fail;
          next_rdata[vcb_pkg::bit_board_fail]  = vcb_pkg::board_fail_init;
        end
        vcb_pkg::vcb_sel_base: begin
          next_rdata[vcb_pkg::window_hi:vcb_pkg::window_lo] = csr_window_select;
        end
        vcb_pkg::vcb_sel_none: begin
          if (shift_sel) begin
            next_rdata[31:vcb_pkg::shift_lo] = addr_shift_field;
          end
        end
      endcase
    end
    // code zero is the parked value after reset, so it never decodes
    next_hit = (csr_addr[vcb_pkg::csr_addr_hi:vcb_pkg::csr_addr_lo] == csr_window_select)
             && (csr_window_select != 5'h00);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata <= 32'h0000_0000;
      hit   <= 1'b0;
    end else begin
      rdata <= next_rdata;
      hit   <= next_hit;
    end
  end

  // ----------------------------------------
  // translation
  // ----------------------------------------
  assign xl.shift    = addr_shift_field;
  assign xl.src_addr = src_addr;

  vcb_xlate u_xlate (
    .clk  (clk),
    .rst  (rst),
    .port (xl.xlate)
  );

  assign dst_addr              = xl.dst_addr;
  assign reg_rdata             = rdata;
  assign csr_hit               = hit;
  assign local_board_reset_out = board_reset;
  assign backplane_fail_drive  = sys_fail;
endmodule

// ==== tb/vcb_master.sv ====
// bus master model for the bank registers
module vcb_master (
  input  wire logic        clk,
  output logic             reg_wr,
  output logic             reg_rd,
  output logic             from_backplane,
  output logic      [11:0] reg_addr,
  output logic      [31:0] reg_wdata,
  output logic      [3:0]  reg_be
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {reg_wr, reg_rd, from_backplane, reg_addr, reg_wdata, reg_be} = '0;
  // one access per call; data lines show the inverse once released
  task automatic acc(input logic w, b, logic [11:0] a, logic [31:0] d, logic [3:0] m);
    @(posedge clk);
    #1 {reg_wr, reg_rd, from_backplane, reg_addr, reg_wdata} = {w, !w, b, a, d};
    reg_be = (a == 12'hffc) ? (m & 4'h8) : m;
    @(posedge clk);
    #1 {reg_wr, reg_rd, reg_wdata} = {2'b00, ~d};
  endtask
endmodule

// ==== tb/vcb_bank_properties.sv ====
// port assertions for the csr bank
module vcb_props (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic        from_backplane,
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic [3:0]  reg_be,
  input wire logic [31:0] reg_rdata,
  input wire logic        local_board_reset_out,
  input wire logic        backplane_fail_drive
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);
  wire lr = local_board_reset_out;
  wire sf = backplane_fail_drive;
  wire ws = reg_wr && reg_be[3] && reg_addr == 12'hff8;
  wire wc = reg_wr && reg_be[3] && reg_addr == 12'hff4;
  wire rc = wc && reg_wdata[31] && from_backplane;
  wire rs = reg_rd && (reg_addr == 12'hff4 || reg_addr == 12'hff8);
  sequence s_fail_low;
    ##1 !reg_rdata[29];
  endsequence
  property p_set; ws && reg_wdata[31] && from_backplane |=> lr; endproperty
  a_set: assert property (p_set) else $error("set");
  property p_clr; rc |=> !lr; endproperty
  a_clr: assert property (p_clr) else $error("clr");
  property p_hold; lr && !rc |=> lr; endproperty
  a_hold: assert property (p_hold) else $error("hold");
  property p_local; !lr && !from_backplane |=> !lr; endproperty
  a_local: assert property (p_local) else $error("local");
  property p_fail; rs |-> s_fail_low; endproperty
  a_fail: assert property (p_fail) else $error("fail");
  property p_mirror; rs |=> reg_rdata[31:30] == {$past(lr), $past(sf)}; endproperty
  a_mirror: assert property (p_mirror) else $error("mirror");
  property p_sfset; ws && reg_wdata[30] |=> sf; endproperty
  a_sfset: assert property (p_sfset) else $error("sfset");
  property p_sfclr; wc && reg_wdata[30] |=> !sf; endproperty
  a_sfclr: assert property (p_sfclr) else $error("sfclr");
endmodule

// ==== tb/vme_csr_set_clear_bank_tb.sv ====
// bench for the csr bank
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin errors++; \
  $display("BAD %0t %h %h", $time, g, e); end end
module vme_csr_set_clear_bank_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, rst, sysfail_strap, reg_wr, reg_rd, from_backplane, csr_hit, w, rm, sm;
  logic        local_board_reset_out, backplane_fail_drive;
  logic [3:0]  reg_be;
  logic [4:0]  wm;
  logic [11:0] reg_addr;
  logic [11:0] tbl [5] = '{12'hff4, 12'hff8, 12'hffc, 12'hfd8, 12'h100};
  logic [15:0] hm;
  logic [23:0] csr_addr;
  logic [31:0] reg_wdata, reg_rdata, src_addr, dst_addr, d, e;
  int          errors, cmp_count;
  vcb_bank vcb_bank_inst (.*);
  vcb_master vcb_master_inst (.*);
  task automatic op();
    {w, d, src_addr} = {1'($urandom), $urandom, $urandom};
    csr_addr = 24'($urandom);
    if ($urandom % 2) csr_addr[23:19] = wm;
    vcb_master_inst.acc(w, 1'($urandom), tbl[$urandom % 5], d, 4'($urandom));
    `CHK(csr_hit, csr_addr[23:19] == wm && wm != 5'h00)
    `CHK(dst_addr, src_addr + {hm, 16'h0})
    e = reg_addr == 12'hffc ? {wm, 27'h0} : reg_addr == 12'hfd8 ? {hm, 16'h0} :
        reg_addr == 12'h100 ? 32'h0 : {rm, sm, 30'h0};
    if (!w) `CHK(reg_rdata, e)
    if (w && reg_be[3] && reg_addr == 12'hff8)
      {rm, sm} = {rm | d[31] & from_backplane, sm | d[30]};
    if (w && reg_be[3] && reg_addr == 12'hff4)
      {rm, sm} = {rm & ~(d[31] & from_backplane), sm & ~d[30]};
    if (w && reg_be[3] && reg_addr == 12'hffc)
      wm = d[31:27];
    if (w && reg_addr == 12'hfd8)
      hm = {reg_be[3] ? d[31:24] : hm[15:8], reg_be[2] ? d[23:16] : hm[7:0]};
    `CHK(local_board_reset_out, rm)
    `CHK(backplane_fail_drive, sm)
  endtask
  // strap lands on the first edge after release, so skip it
  task automatic reset_dut(input logic s);
    {rst, sysfail_strap, rm, sm, wm, hm} = {1'b1, s, 1'b0, s, 21'h0};
    repeat (3) @(posedge clk);
    #1 rst = 1'b0;
    @(posedge clk);
    #1;
  endtask
  task automatic test_done();
    $display("errors %0d of %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial forever #50 clk = ~clk;
  initial begin
    #100000 errors++;
    test_done();
  end
  initial begin
    void'($urandom(32'he2a47352));
    {clk, csr_addr, src_addr} = '0;
    reset_dut(1'b1);
    repeat (80) op();
    // code 31 is the last of the 31 windows and must still decode
    vcb_master_inst.acc(1'b1, 1'b1, 12'hffc, 32'hf800_0000, 4'h8);
    {wm, csr_addr} = {5'h1f, 24'hf8_0000};
    vcb_master_inst.acc(1'b0, 1'b1, 12'hffc, 32'h0000_0000, 4'h8);
    `CHK(csr_hit, 1'b1)
    `CHK(reg_rdata, 32'hf800_0000)
    reset_dut(1'b0);
    repeat (80) op();
    test_done();
  end
endmodule
bind vcb_bank vcb_props vcb_props_inst (.*);
